// ==== rtl/posc_pkg.sv ====
// package: states, codes and timing constants of the on/off controller
package posc_pkg;
  localparam int unsigned POSC_CLK_HZ = 50_000_000;
  // charge-source debounce time in milliseconds
  localparam int unsigned POSC_CHG_DB_MS = 120;
  localparam int unsigned POSC_CHG_DB_CYC = POSC_CHG_DB_MS * (POSC_CLK_HZ / 1000);
  // stabilization time for internal signals and memory, in microseconds
  localparam int unsigned POSC_STAB_US = 100;
  localparam int unsigned POSC_STAB_CYC = POSC_STAB_US * (POSC_CLK_HZ / 1_000_000);
  // onkey debounce time in milliseconds
  localparam int unsigned POSC_KEY_DB_MS = 30;
  localparam int unsigned POSC_KEY_DB_CYC = POSC_KEY_DB_MS * (POSC_CLK_HZ / 1000);
  localparam logic [1:0] POSC_SRST_NONE = 2'h0;
  localparam logic [1:0] POSC_SRST_COLD = 2'h1;
  localparam logic [1:0] POSC_SRST_OFF = 2'h2;
  typedef enum logic [3:0] {
    POSC_NO_POWER,
    POSC_STABILIZE,
    POSC_STANDBY,
    POSC_ON_SW,
    POSC_WAKE_BIAS,
    POSC_POWER_UP,
    POSC_ON_CTRL,
    POSC_POWER_DOWN
  } posc_state_e;
endpackage : posc_pkg

// ==== rtl/posc_dbnc_if.sv ====
// interface: raw level in, debounced level and edges out
interface posc_dbnc_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport filt (input raw, output level, rise, fall);
  modport user (output raw, input level, rise, fall);
endinterface : posc_dbnc_if

// ==== rtl/posc_debounce.sv ====
// module: three-flop synchroniser and stable-time debounce filter
module posc_debounce
  import posc_pkg::*;
#(
  parameter int unsigned CYCLES = 16,
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  posc_dbnc_if.filt d
);
  localparam int W = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("posc_debounce: CYCLES must be at least 1");
  end
  logic s1_ff, s2_ff, s3_ff;
  logic lvl_ff, rise_ff, fall_ff;
  logic [W-1:0] cnt_ff;
  wire logic stable = (s2_ff == s3_ff);
  wire logic differ = (s3_ff != lvl_ff);
  wire logic done = (cnt_ff == W'(CYCLES - 1));
  // first flop feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= d.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // level must hold for the whole period before the output follows
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      lvl_ff <= INIT;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      if (!stable || !differ) begin
        cnt_ff <= '0;
      end else if (done) begin
        cnt_ff <= '0;
        lvl_ff <= s3_ff;
        rise_ff <= s3_ff;
        fall_ff <= !s3_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
  assign d.level = lvl_ff;
  assign d.rise = rise_ff;
  assign d.fall = fall_ff;
endmodule : posc_debounce

// ==== rtl/posc_wake_filter.sv ====
// module: gathers wake sources into one pulse-or-level request
module posc_wake_filter
  import posc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic onkey_fall,
  input wire logic onkey_wake_enable,
  input wire logic charge_rise,
  input wire logic gpio_wake_event,
  input wire logic internal_wake_flag,
  input wire logic in_standby,
  output logic wake_request
);
  // edge events act in the cycle they arrive; nothing is stored, so a
  // wake seen while on cannot fire later from a stale latch
  wire logic edge_evt = (onkey_fall && onkey_wake_enable) || charge_rise
    || gpio_wake_event;
  // edges only count in standby; while on they are dropped
  assign wake_request = in_standby && (edge_evt || internal_wake_flag);
endmodule : posc_wake_filter

// ==== rtl/posc_controller.sv ====
// top: power on/off state controller
// Operation
// RQ1: supply below power-on-reset threshold returns to no-power from any state
// RQ2: supply above threshold leaves no-power and starts internal stabilization
// RQ3: after stabilization, release internal reset and enter standby
// RQ4: standby keeps bias off, comparator on, peripherals disabled
// RQ5: host setting bias enable in standby moves to on-by-software
// RQ6: host clearing bias enable in on-by-software returns to standby
// RQ7: on-by-software has bias on; peripherals only by host writes
// RQ8: host disables resources first and avoids reset codes in that mode
// RQ9: debounced onkey falling edge wakes standby when onkey wake enabled
// RQ10: charge-source rising edge debounced about 120ms wakes standby
// RQ11: cold-restart write sets internal wake flag, which wakes standby
// RQ12: debounced wake from any enabled gpio wakes standby
// RQ13: after wake, enable bias and wait for bias-OK before power-up
// RQ14: on-by-controller turns all sequencer slots on with bias enabled
// RQ15: on-by-controller runs bias in normal-power mode, indicator high
// RQ16: reset code 01 cold reset, 10 power off, leaves on toward power-down
// RQ17: onkey or gpio manual reset leaves on toward power-down
// RQ18: power-up complete enters on state; wakes while on are ignored (a cold-restart write while on still sets the flag, which wakes standby later)
// RQ19: reset leaves state at no-power and bias enable cleared
module posc_controller
  import posc_pkg::*;
#(
  parameter int unsigned CHG_DB_CYCLES = POSC_CHG_DB_CYC,
  parameter int unsigned KEY_DB_CYCLES = POSC_KEY_DB_CYC,
  parameter int unsigned STAB_CYCLES = POSC_STAB_CYC,
  parameter int unsigned SLOTS = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supply_above_por,
  input wire logic onkey_input_n,
  input wire logic onkey_wake_enable,
  input wire logic charge_source_input,
  input wire logic gpio_wake_event,
  input wire logic main_bias_enable,
  input wire logic soft_cold_restart,
  input wire logic soft_reset_write,
  input wire logic [1:0] soft_reset_code,
  input wire logic onkey_manual_reset_event,
  input wire logic gpio_manual_reset_event,
  input wire logic bias_ok,
  input wire logic power_up_done,
  input wire logic power_down_done,
  output logic bias_on,
  output logic comparator_on,
  output logic peripherals_host_ctrl,
  output logic [SLOTS-1:0] power_sequencer,
  output logic normal_power_mode,
  output logic power_up_start,
  output logic power_down_start,
  output logic cold_reset_pending,
  output logic internal_reset_n,
  output logic internal_wake_flag,
  output logic [3:0] state_code
);
  initial begin
    if (SLOTS < 1) $error("posc_controller: SLOTS must be at least 1");
    if (STAB_CYCLES < 1) $error("posc_controller: STAB_CYCLES too small");
  end

  // reset release through two flops
  logic rs1_ff, rs2_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  wire logic rst_n = rs2_ff;

  // supply comparator is asynchronous: three flops, act when 2nd and 3rd agree
  logic p1_ff, p2_ff, p3_ff, por_ok_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
      p3_ff <= 1'b0;
      por_ok_ff <= 1'b0;
    end else begin
      p1_ff <= supply_above_por;
      p2_ff <= p1_ff;
      p3_ff <= p2_ff;
      if (p2_ff == p3_ff) por_ok_ff <= p3_ff;
    end
  end

  // debounced pins
  posc_dbnc_if key_if ();
  posc_dbnc_if chg_if ();
  assign key_if.raw = onkey_input_n;
  assign chg_if.raw = charge_source_input;
  posc_debounce #(.CYCLES(KEY_DB_CYCLES), .INIT(1'b1)) u_key_db (
    .clock(clock),
    .rst_n(rst_n),
    .d(key_if.filt)
  );
  posc_debounce #(.CYCLES(CHG_DB_CYCLES), .INIT(1'b0)) u_chg_db (
    .clock(clock),
    .rst_n(rst_n),
    .d(chg_if.filt)
  );

  posc_state_e state_ff, nxt_state;
  logic internal_wake_flag_ff, nxt_internal_wake_flag;
  logic cold_ff, nxt_cold;
  logic [$clog2(STAB_CYCLES + 1)-1:0] stab_ff, nxt_stab;
  wire logic in_standby = (state_ff == POSC_STANDBY);
  wire logic wake_req;

  posc_wake_filter u_wake (
    .clock(clock),
    .rst_n(rst_n),
    .onkey_fall(key_if.fall), // [RQ9]
    .onkey_wake_enable(onkey_wake_enable),
    .charge_rise(chg_if.rise), // [RQ10]
    .gpio_wake_event(gpio_wake_event), // [RQ12]
    .internal_wake_flag(internal_wake_flag_ff), // [RQ11]
    .in_standby(in_standby),
    .wake_request(wake_req)
  );

  // decoded shutdown request from reset code or manual reset
  wire logic srst_valid = soft_reset_write
    && (soft_reset_code == POSC_SRST_COLD || soft_reset_code == POSC_SRST_OFF);
  wire logic mr_evt = onkey_manual_reset_event || gpio_manual_reset_event;
  wire logic stab_done = (stab_ff == $bits(stab_ff)'(STAB_CYCLES - 1));

  // state transitions; the supply check overrides every state
  always_comb begin
    nxt_state = state_ff;
    nxt_stab = '0;
    nxt_internal_wake_flag = internal_wake_flag_ff;
    nxt_cold = cold_ff;
    // set wins over the clear taken on wake-up
    if (soft_cold_restart) nxt_internal_wake_flag = 1'b1; // [RQ11]
    unique case (state_ff)
      POSC_NO_POWER: begin
        if (por_ok_ff) nxt_state = POSC_STABILIZE; // [RQ2]
      end
      POSC_STABILIZE: begin
        nxt_stab = stab_ff + 1'b1;
        if (stab_done) nxt_state = POSC_STANDBY; // [RQ3]
      end
      POSC_STANDBY: begin
        if (main_bias_enable) begin
          nxt_state = POSC_ON_SW; // [RQ5]
        end else if (wake_req) begin
          nxt_state = POSC_WAKE_BIAS;
          if (!soft_cold_restart) nxt_internal_wake_flag = 1'b0;
        end
      end
      POSC_ON_SW: begin
        if (!main_bias_enable) nxt_state = POSC_STANDBY; // [RQ6]
      end
      POSC_WAKE_BIAS: begin
        if (bias_ok) nxt_state = POSC_POWER_UP; // [RQ13]
      end
      POSC_POWER_UP: begin
        if (power_up_done) nxt_state = POSC_ON_CTRL; // [RQ18]
      end
      POSC_ON_CTRL: begin
        if (srst_valid || mr_evt) begin
          nxt_state = POSC_POWER_DOWN; // [RQ16] [RQ17]
          nxt_cold = srst_valid && (soft_reset_code == POSC_SRST_COLD);
        end
      end
      POSC_POWER_DOWN: begin
        if (power_down_done) begin
          nxt_state = POSC_STANDBY;
          if (cold_ff) nxt_internal_wake_flag = 1'b1; // cold reset wakes again
          nxt_cold = 1'b0;
        end
      end
      default: nxt_state = POSC_NO_POWER;
    endcase
    if (!por_ok_ff) begin
      nxt_state = POSC_NO_POWER; // [RQ1]
      nxt_internal_wake_flag = 1'b0;
      nxt_cold = 1'b0;
    end
  end

  // state register, cleared to no-power so stabilization always comes first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= POSC_NO_POWER; // [RQ19]
      stab_ff <= '0;
      internal_wake_flag_ff <= 1'b0;
      cold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stab_ff <= nxt_stab;
      internal_wake_flag_ff <= nxt_internal_wake_flag;
      cold_ff <= nxt_cold;
    end
  end

  // state-driven outputs, registered
  logic bias_ff, cmp_ff, host_ff, npm_ff, pus_ff, pds_ff, irst_ff;
  logic [SLOTS-1:0] seq_ff;
  wire logic st_on_sw = (nxt_state == POSC_ON_SW);
  wire logic st_on = (nxt_state == POSC_ON_CTRL);
  wire logic st_bias = st_on_sw || st_on || nxt_state == POSC_WAKE_BIAS
    || nxt_state == POSC_POWER_UP || nxt_state == POSC_POWER_DOWN;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bias_ff <= 1'b0;
      cmp_ff <= 1'b0;
      host_ff <= 1'b0;
      npm_ff <= 1'b0;
      seq_ff <= '0;
      pus_ff <= 1'b0;
      pds_ff <= 1'b0;
      irst_ff <= 1'b0;
    end else begin
      bias_ff <= st_bias; // [RQ4] [RQ13]
      cmp_ff <= (nxt_state != POSC_NO_POWER); // [RQ4]
      host_ff <= st_on_sw; // [RQ7] [RQ8]
      npm_ff <= st_on; // [RQ15]
      seq_ff <= st_on ? '1 : '0; // [RQ14]
      pus_ff <= (nxt_state == POSC_POWER_UP);
      pds_ff <= (nxt_state == POSC_POWER_DOWN);
      irst_ff <= (nxt_state != POSC_NO_POWER)
        && (nxt_state != POSC_STABILIZE); // [RQ3]
    end
  end

  assign bias_on = bias_ff;
  assign comparator_on = cmp_ff;
  assign peripherals_host_ctrl = host_ff;
  assign power_sequencer = seq_ff;
  assign normal_power_mode = npm_ff;
  assign power_up_start = pus_ff;
  assign power_down_start = pds_ff;
  assign cold_reset_pending = cold_ff;
  assign internal_reset_n = irst_ff;
  assign internal_wake_flag = internal_wake_flag_ff;
  assign state_code = state_ff;
endmodule : posc_controller

// ==== sim/posc_seq_model.sv ====
// model of the sequencer side: bias and sequence acknowledges
module posc_seq_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic bias_on,
  input wire logic power_up_start,
  input wire logic power_down_start,
  output logic bias_ok,
  output logic power_up_done,
  output logic power_down_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] req;
  logic [2:0] prev = 3'h0;
  int cnt = 0;
  assign req = {bias_on, power_up_start, power_down_start};
  initial {bias_ok, power_up_done, power_down_done} = 3'h0;
  // count restarts on every request change; acks drop with the request
  always @(posedge clock) begin
    prev <= req;
    cnt <= (req == prev) ? cnt + 1 : 0;
    bias_ok <= bias_on && cnt >= (slow ? 9 : 1);
    power_up_done <= power_up_start && cnt >= (slow ? 12 : 2);
    power_down_done <= power_down_start && cnt >= 2;
  end
endmodule // posc_seq_model

// ==== sim/posc_controller_sva.sv ====
// checker: port-level assertions for the on/off controller
module posc_controller_sva #(
  parameter int unsigned SLOTS = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supply_above_por,
  input wire logic main_bias_enable,
  input wire logic soft_reset_write,
  input wire logic [1:0] soft_reset_code,
  input wire logic onkey_manual_reset_event,
  input wire logic gpio_manual_reset_event,
  input wire logic bias_ok,
  input wire logic power_up_done,
  input wire logic bias_on,
  input wire logic comparator_on,
  input wire logic [SLOTS-1:0] power_sequencer,
  input wire logic normal_power_mode,
  input wire logic power_up_start,
  input wire logic internal_reset_n,
  input wire logic [3:0] state_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // only codes 01 and 10 count; 00 and 11 are refused
  wire srst_go = soft_reset_write && soft_reset_code inside {2'h1, 2'h2};
  wire leave = srst_go || onkey_manual_reset_event || gpio_manual_reset_event;
  // supply sync takes a few flops, so allow a short window
  supply_loss_a: assert property (
    $fell(supply_above_por) |-> ##[1:8] state_code == 4'h0) else $error("late");
  reset_release_a: assert property (
    $rose(internal_reset_n) |-> state_code == 4'h2) else $error("release");
  standby_outs_a: assert property (
    state_code == 4'h2 |-> !bias_on && comparator_on) else $error("standby");
  sw_entry_a: assert property (
    state_code == 4'h2 && main_bias_enable |=> state_code == 4'h3)
    else $error("sw entry");
  sw_exit_a: assert property (
    state_code == 4'h3 && !main_bias_enable |=> state_code == 4'h2)
    else $error("sw exit");
  bias_wait_a: assert property (
    state_code == 4'h4 |=> state_code == ($past(bias_ok) ? 4'h5 : 4'h4)
    && bias_on && power_up_start == (state_code == 4'h5)) else $error("bias");
  up_done_a: assert property (
    state_code == 4'h5 && power_up_done |=> state_code == 4'h6)
    else $error("up done");
  on_outs_a: assert property (
    state_code == 4'h6 |-> &power_sequencer && bias_on && normal_power_mode)
    else $error("on outputs");
  leave_on_a: assert property (
    state_code == 4'h6 && leave |=> state_code == 4'h7) else $error("leave");
  stay_on_a: assert property (
    state_code == 4'h6 && !leave && supply_above_por |=> state_code == 4'h6)
    else $error("stay on");
  cover property (state_code == 4'h3);
  cover property (state_code == 4'h6 ##1 state_code == 4'h7);
  cover property ($fell(supply_above_por));
endmodule // posc_controller_sva
bind posc_controller posc_controller_sva #(.SLOTS(SLOTS)) posc_controller_sva_i (
  .clock, .reset_n, .supply_above_por, .main_bias_enable, .soft_reset_write,
  .soft_reset_code, .onkey_manual_reset_event, .gpio_manual_reset_event,
  .bias_ok, .power_up_done, .bias_on, .comparator_on, .power_sequencer,
  .normal_power_mode, .power_up_start, .internal_reset_n, .state_code);

// ==== sim/posc_controller_bench.sv ====
// self-checking bench for the power on/off state controller
module posc_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, supply_above_por, onkey_input_n, onkey_wake_enable;
  logic charge_source_input, gpio_wake_event, main_bias_enable, slow;
  logic soft_cold_restart, soft_reset_write, onkey_manual_reset_event;
  logic gpio_manual_reset_event, bias_ok, power_up_done, power_down_done;
  logic bias_on, comparator_on, peripherals_host_ctrl, normal_power_mode;
  logic power_up_start, power_down_start, cold_reset_pending;
  logic internal_reset_n, internal_wake_flag;
  logic [1:0] soft_reset_code;
  logic [3:0] power_sequencer, state_code;
  int n_errors = 0, checks_done = 0, cycles = 0;
  // short counts keep debounce and stabilization waits brief
  posc_controller #(.CHG_DB_CYCLES(8), .KEY_DB_CYCLES(4), .STAB_CYCLES(4))
    posc_controller_i (.clock, .reset_n, .supply_above_por, .onkey_input_n,
    .onkey_wake_enable, .charge_source_input, .gpio_wake_event,
    .main_bias_enable, .soft_cold_restart, .soft_reset_write,
    .soft_reset_code, .onkey_manual_reset_event, .gpio_manual_reset_event,
    .bias_ok, .power_up_done, .power_down_done, .bias_on, .comparator_on,
    .peripherals_host_ctrl, .power_sequencer, .normal_power_mode,
    .power_up_start, .power_down_start, .cold_reset_pending,
    .internal_reset_n, .internal_wake_flag, .state_code);
  posc_seq_model posc_seq_model_i (.clock, .slow, .bias_on, .power_up_start,
    .power_down_start, .bias_ok, .power_up_done, .power_down_done);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hang is cut short here and counted as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_st(input logic [3:0] s);
    #1;
    for (int i = 0; i < 300 && state_code !== s; i++) begin
      @(posedge clock);
      #1;
    end
    chk("state", s, state_code);
  endtask
  // one-cycle strobe on the request inputs, code held with it
  task automatic kick(input logic [1:0] c, input logic [4:0] v);
    @(posedge clock);
    soft_reset_code <= c;
    {soft_cold_restart, soft_reset_write, onkey_manual_reset_event,
      gpio_manual_reset_event, gpio_wake_event} <= v;
    @(posedge clock);
    {soft_cold_restart, soft_reset_write, onkey_manual_reset_event,
      gpio_manual_reset_event, gpio_wake_event} <= 5'h00;
  endtask
  task automatic t_por;
    @(posedge clock) supply_above_por <= 1'b0;
    wait_st(4'h0);
    chk("rst", 4'h0, {3'h0, internal_reset_n});
    @(posedge clock) supply_above_por <= 1'b1;
    wait_st(4'h1);
    wait_st(4'h2);
    chk("rst", 4'h1, {3'h0, internal_reset_n});
  endtask
  task automatic t_sw;
    @(posedge clock) main_bias_enable <= 1'b1;
    wait_st(4'h3);
    chk("host", 4'h1, {3'h0, peripherals_host_ctrl & bias_on});
    @(posedge clock) main_bias_enable <= 1'b0;
    wait_st(4'h2);
    chk("bias", 4'h2, {2'h0, comparator_on, bias_on});
  endtask
  task automatic t_key_off;
    @(posedge clock) onkey_input_n <= 1'b0;
    repeat (20) @(posedge clock);
    #1 chk("state", 4'h2, state_code);
    @(posedge clock) onkey_input_n <= 1'b1;
    repeat (20) @(posedge clock);
    onkey_wake_enable <= 1'b1;
  endtask
  // wake source s, then leave the on state by exit path s
  task automatic t_wake(input int s);
    @(posedge clock) slow <= (s == 1);
    if (s == 0) onkey_input_n <= 1'b0;
    if (s == 1) charge_source_input <= 1'b1;
    if (s == 2) kick(2'h0, 5'h10);
    if (s == 3) kick(2'h0, 5'h01);
    wait_st(4'h6);
    {onkey_input_n, charge_source_input} <= 2'h2;
    chk("npm", 4'h1, {3'h0, normal_power_mode});
    chk("slots", 4'hF, power_sequencer);
    kick(2'h0, 5'h01);
    kick(2'h3, 5'h08);
    repeat (3) @(posedge clock);
    #1 chk("state", 4'h6, state_code);
    if (s < 2) kick(s[1:0] + 2'h1, 5'h08);
    else kick(2'h0, (s == 2) ? 5'h04 : 5'h02);
    wait_st(4'h7);
    chk("pds", 4'h1, {3'h0, power_down_start});
    chk("cold", {3'h0, s == 0}, {3'h0, cold_reset_pending});
    wait_st((s == 0) ? 4'h6 : 4'h2);
    if (s == 0) begin
      kick(2'h2, 5'h08);
      wait_st(4'h2);
    end
  endtask
  initial begin
    {reset_n, supply_above_por, onkey_wake_enable, slow} = 4'h0;
    {charge_source_input, gpio_wake_event, main_bias_enable} = 3'h0;
    {soft_cold_restart, soft_reset_write, onkey_manual_reset_event} = 3'h0;
    gpio_manual_reset_event = 1'b0;
    soft_reset_code = 2'h0;
    onkey_input_n = 1'b1;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    #1 chk("state", 4'h0, state_code);
    t_por;
    t_sw;
    t_key_off;
    for (int i = 0; i < 4; i++) t_wake(i);
    t_por;
    test_done;
  end
endmodule // posc_controller_bench
